/* core/ccs_regs.svh */
`ifndef CCS_REGS_SVH
`define CCS_REGS_SVH

`define CCS_CLK_NS          5
`define CCS_RST_HOLD_NS     1000
`define CCS_RST_HOLD_CYC    ((`CCS_RST_HOLD_NS + `CCS_CLK_NS - 1) / `CCS_CLK_NS)
`define CCS_SETTLE_NS       2000
`define CCS_SETTLE_CYC      ((`CCS_SETTLE_NS + `CCS_CLK_NS - 1) / `CCS_CLK_NS)
`define CCS_CNT_W           10

`define CCS_ADDR_W          4
`define CCS_ADDR_CTRL       4'h0
`define CCS_ADDR_STATUS     4'h4
`define CCS_ADDR_OCC        4'h8
`define CCS_ADDR_EVCNT      4'hc

`define CCS_CTRL_RESTART    0
`define CCS_CTRL_MCQ        1
`define CCS_CTRL_AUTO       2
`define CCS_CTRL_MCQ_RST    1'h0
`define CCS_CTRL_AUTO_RST   1'h1

`define CCS_STS_AUDIO       0
`define CCS_STS_MODEM       1
`define CCS_STS_REASON      2
`define CCS_STS_STATE       8
`define CCS_STS_SEL         12
`define CCS_STS_LINK        13
`define CCS_STS_PEND        14

`define CCS_OCC_PRI         0
`define CCS_OCC_SEC         8
`define CCS_OCC_RSADDR      16
`define CCS_OCC_RSSINGLE    20

`endif

/* core/ccs_pkg.sv */
`include "ccs_regs.svh"
package ccs_pkg;

   typedef enum logic [1:0] {
      CCS_ST_HOLD   = 2'b00,
      CCS_ST_SETTLE = 2'b01,
      CCS_ST_EVAL   = 2'b10,
      CCS_ST_RUN    = 2'b11
   } ccs_state_t;

   typedef enum logic [2:0] {
      CCS_RSN_NONE       = 3'h0,
      CCS_RSN_NO_PRIMARY = 3'h1,
      CCS_RSN_DUAL_CLAIM = 3'h2,
      CCS_RSN_AUDIO_SEC  = 3'h3,
      CCS_RSN_MULTI_MDM  = 3'h4,
      CCS_RSN_MC_UNQUAL  = 3'h5,
      CCS_RSN_NO_AUDIO   = 3'h6
   } ccs_reason_t;

   typedef struct packed {
      logic [1:0] cnt;
      logic       audio;
      logic       modem;
   } ccs_slot_t;

   typedef struct packed {
      logic        audio_en;
      logic        modem_en;
      ccs_reason_t reason;
   } ccs_result_t;

   typedef struct packed {
      logic [1:0] mb_rst_n;
      logic [1:0] mb_addr;
      logic [1:0] rs_addr;
      logic [1:0] rs_sdin;
      logic       rs_single;
   } ccs_route_st_t;

   typedef struct packed {
      ccs_state_t                state;
      logic [`CCS_CNT_W-1:0]     cnt;
      logic                      link_rst_n;
      logic                      sel_n_seen;
      logic                      restart_req;
      logic                      mcq;
      logic                      auto_rs;
      ccs_result_t               res;
      ccs_slot_t                 occ_p;
      ccs_slot_t                 occ_s;
      logic [15:0]               ev_cnt;
      logic [31:0]               rdata;
   } ccs_core_st_t;

endpackage

/* core/ccs_route.sv */
`timescale 1ns/100ps
module ccs_route
   import ccs_pkg::*;
(
   input  wire logic       core_clk_in,
   input  wire logic       rst_n_in,
   input  wire logic       link_rst_n_in,
   input  wire logic       codec_down_select_n_in,
   input  wire logic [1:0] mb_addr_in,
   input  wire logic [1:0] rs_present_in,
   input  wire logic [1:0] rs_base_addr_in,
   output logic      [1:0] mb_codec_reset_n_out,
   output logic      [1:0] mb_addr_out,
   output logic      [1:0] rs_addr_out,
   output logic      [1:0] rs_sdin_sel_out,
   output logic            rs_single_out
);

   ccs_route_st_t st_ff;
   ccs_route_st_t nxt_st;

   always_comb begin
      nxt_st           = st_ff;
      // Held in reset, not just muted, so the riser owns the link
      nxt_st.mb_rst_n  = {2{link_rst_n_in & ~codec_down_select_n_in}};
      nxt_st.mb_addr   = mb_addr_in;
      nxt_st.rs_single = ^rs_present_in;
      for (int i = 0; i < 2; i++) begin
         nxt_st.rs_addr[i] = rs_base_addr_in[i];
         // Next free slot above the base is always the secondary one
         if (nxt_st.rs_single && rs_present_in[i] && !codec_down_select_n_in) begin
            nxt_st.rs_addr[i] = 1'b1;
         end
      end
      nxt_st.rs_sdin   = nxt_st.rs_addr;
   end

   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign mb_codec_reset_n_out = st_ff.mb_rst_n;
   assign mb_addr_out          = st_ff.mb_addr;
   assign rs_addr_out          = st_ff.rs_addr;
   assign rs_sdin_sel_out      = st_ff.rs_sdin;
   assign rs_single_out        = st_ff.rs_single;

endmodule // ccs_route

/* core/ccs_matrix.sv */
`timescale 1ns/100ps
`include "ccs_regs.svh"

module ccs_matrix
   import ccs_pkg::*;
(
   input  wire logic                   core_clk_in,
   input  wire logic                   nrst_in,
   input  wire logic                   codec_down_select_n_in,
   input  wire logic [1:0]             mb_present_in,
   input  wire logic [1:0]             mb_audio_in,
   input  wire logic [1:0]             mb_modem_in,
   input  wire logic [1:0]             mb_addr_in,
   input  wire logic [1:0]             rs_present_in,
   input  wire logic [1:0]             rs_audio_in,
   input  wire logic [1:0]             rs_modem_in,
   input  wire logic [1:0]             rs_base_addr_in,
   input  wire logic [`CCS_ADDR_W-1:0] reg_addr_in,
   input  wire logic [31:0]            reg_wdata_in,
   input  wire logic                   reg_wr_in,
   input  wire logic                   reg_rd_in,
   output logic      [31:0]            reg_rdata_out,
   output logic                        codec_link_reset_n_out,
   output logic      [1:0]             mb_codec_reset_n_out,
   output logic      [1:0]             mb_addr_out,
   output logic      [1:0]             rs_addr_out,
   output logic      [1:0]             rs_sdin_sel_out,
   output logic                        audio_en_out,
   output logic                        modem_en_out
);

   logic [1:0]   rst_sync_ff;
   logic         rst_n;
   logic         rs_single;
   logic [3:0]   act;
   logic [3:0]   adr;
   logic [3:0]   aud;
   logic [3:0]   mdm;
   ccs_slot_t    occ_p;
   ccs_slot_t    occ_s;
   ccs_core_st_t st_ff;
   ccs_core_st_t nxt_st;

   // Reset release synchroniser
   always_ff @(posedge core_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         rst_sync_ff <= 2'h0;
      end else begin
         rst_sync_ff <= {rst_sync_ff[0], 1'b1};
      end
   end

   assign rst_n = rst_sync_ff[1];

   ccs_route u_route (
      .core_clk_in            (core_clk_in),
      .rst_n_in               (rst_n),
      .link_rst_n_in          (st_ff.link_rst_n),
      .codec_down_select_n_in (codec_down_select_n_in),
      .mb_addr_in             (mb_addr_in),
      .rs_present_in          (rs_present_in),
      .rs_base_addr_in        (rs_base_addr_in),
      .mb_codec_reset_n_out   (mb_codec_reset_n_out),
      .mb_addr_out            (mb_addr_out),
      .rs_addr_out            (rs_addr_out),
      .rs_sdin_sel_out        (rs_sdin_sel_out),
      .rs_single_out          (rs_single)
   );

   // Count and type of every live codec answering at one address
   function automatic ccs_slot_t ccs_occ(
      input logic       want,
      input logic [3:0] a_act,
      input logic [3:0] a_adr,
      input logic [3:0] a_aud,
      input logic [3:0] a_mdm
   );
      ccs_slot_t o;
      o = '0;
      for (int i = 0; i < 4; i++) begin
         if (a_act[i] && (a_adr[i] == want)) begin
            // Count saturates at two: a third claimant still ORs in its audio and modem type
            if (o.cnt != 2'h2) begin
               o.cnt = o.cnt + 2'h1;
            end
            o.audio = o.audio | a_aud[i];
            o.modem = o.modem | a_mdm[i];
         end
      end
      return o;
   endfunction

   function automatic ccs_result_t ccs_decide(
      input ccs_slot_t p,
      input ccs_slot_t s,
      input logic      mcq
   );
      ccs_result_t r;
      r = '{audio_en: 1'b0, modem_en: 1'b0, reason: CCS_RSN_NONE};
      if ((p.cnt > 2'h1) || (s.cnt > 2'h1)) begin
         r.reason = CCS_RSN_DUAL_CLAIM;
      end else if (p.cnt == 2'h0) begin
         r.reason = CCS_RSN_NO_PRIMARY;
      end else if (s.cnt == 2'h0) begin
         r.audio_en = p.audio;
         r.modem_en = p.modem;
         if (!p.audio) begin
            r.reason = CCS_RSN_NO_AUDIO;
         end
      end else if (!p.audio && s.audio && !s.modem) begin
         r.reason = CCS_RSN_AUDIO_SEC;
      end else begin
         r.modem_en = p.modem ^ s.modem;
         if (p.audio && s.audio) begin
            r.audio_en = mcq;
         end else begin
            r.audio_en = p.audio | s.audio;
         end
         if (p.audio && s.audio && !mcq) begin
            r.reason = CCS_RSN_MC_UNQUAL;
         end else if (p.modem && s.modem) begin
            r.reason = CCS_RSN_MULTI_MDM;
         end else if (!r.audio_en) begin
            r.reason = CCS_RSN_NO_AUDIO;
         end
      end
      return r;
   endfunction

   // Motherboard codecs drop out of the count while select is high
   always_comb begin
      act = {rs_present_in, mb_present_in & {2{~codec_down_select_n_in}}};
      adr = {rs_addr_out, mb_addr_out};
      aud = {rs_audio_in, mb_audio_in};
      mdm = {rs_modem_in, mb_modem_in};
      occ_p = ccs_occ(1'b0, act, adr, aud, mdm);
      occ_s = ccs_occ(1'b1, act, adr, aud, mdm);
   end

   always_comb begin
      nxt_st       = st_ff;
      nxt_st.rdata = 32'h0;

      // Register writes; a restart request, set after the state case, beats its own clear
      if (reg_wr_in && (reg_addr_in == `CCS_ADDR_CTRL)) begin
         nxt_st.mcq     = reg_wdata_in[`CCS_CTRL_MCQ];
         nxt_st.auto_rs = reg_wdata_in[`CCS_CTRL_AUTO];
      end

      case (st_ff.state)
         CCS_ST_HOLD: begin
            nxt_st.link_rst_n  = 1'b0;
            nxt_st.res         = '0;
            nxt_st.restart_req = 1'b0;
            if (st_ff.cnt == `CCS_CNT_W'(`CCS_RST_HOLD_CYC - 1)) begin
               nxt_st.cnt        = '0;
               nxt_st.link_rst_n = 1'b1;
               nxt_st.state      = CCS_ST_SETTLE;
            end else begin
               nxt_st.cnt = st_ff.cnt + `CCS_CNT_W'(1);
            end
         end
         CCS_ST_SETTLE: begin
            // Codecs need time after reset before their type is trusted
            nxt_st.res = '0;
            if (st_ff.cnt == `CCS_CNT_W'(`CCS_SETTLE_CYC - 1)) begin
               nxt_st.cnt   = '0;
               nxt_st.state = CCS_ST_EVAL;
            end else begin
               nxt_st.cnt = st_ff.cnt + `CCS_CNT_W'(1);
            end
         end
         CCS_ST_EVAL: begin
            nxt_st.res        = ccs_decide(occ_p, occ_s, st_ff.mcq);
            nxt_st.occ_p      = occ_p;
            nxt_st.occ_s      = occ_s;
            nxt_st.sel_n_seen = codec_down_select_n_in;
            nxt_st.ev_cnt     = st_ff.ev_cnt + 16'h0001;
            nxt_st.state      = CCS_ST_RUN;
         end
         CCS_ST_RUN: begin
            // A select flip reshuffles the link, so the old verdict is stale
            if (st_ff.restart_req ||
                (st_ff.auto_rs && (codec_down_select_n_in != st_ff.sel_n_seen))) begin
               nxt_st.res   = '0;
               nxt_st.cnt   = '0;
               nxt_st.state = CCS_ST_HOLD;
            end
         end
         default: begin
            nxt_st.cnt   = '0;
            nxt_st.state = CCS_ST_HOLD;
         end
      endcase

      if (reg_wr_in && (reg_addr_in == `CCS_ADDR_CTRL) && reg_wdata_in[`CCS_CTRL_RESTART]) begin
         nxt_st.restart_req = 1'b1;
      end

      // Read data stand for exactly one cycle; unmapped reads give zero
      if (reg_rd_in) begin
         case (reg_addr_in)
            `CCS_ADDR_CTRL: begin
               nxt_st.rdata[`CCS_CTRL_MCQ]  = st_ff.mcq;
               nxt_st.rdata[`CCS_CTRL_AUTO] = st_ff.auto_rs;
            end
            `CCS_ADDR_STATUS: begin
               nxt_st.rdata[`CCS_STS_AUDIO]                      = st_ff.res.audio_en;
               nxt_st.rdata[`CCS_STS_MODEM]                      = st_ff.res.modem_en;
               nxt_st.rdata[`CCS_STS_REASON+2:`CCS_STS_REASON]   = st_ff.res.reason;
               nxt_st.rdata[`CCS_STS_STATE+1:`CCS_STS_STATE]     = st_ff.state;
               nxt_st.rdata[`CCS_STS_SEL]                        = st_ff.sel_n_seen;
               nxt_st.rdata[`CCS_STS_LINK]                       = st_ff.link_rst_n;
               nxt_st.rdata[`CCS_STS_PEND]                       = st_ff.restart_req;
            end
            `CCS_ADDR_OCC: begin
               nxt_st.rdata[`CCS_OCC_PRI+3:`CCS_OCC_PRI]         = st_ff.occ_p;
               nxt_st.rdata[`CCS_OCC_SEC+3:`CCS_OCC_SEC]         = st_ff.occ_s;
               nxt_st.rdata[`CCS_OCC_RSADDR+1:`CCS_OCC_RSADDR]   = rs_addr_out;
               nxt_st.rdata[`CCS_OCC_RSSINGLE]                   = rs_single;
            end
            `CCS_ADDR_EVCNT: begin
               nxt_st.rdata[15:0] = st_ff.ev_cnt;
            end
            default: begin
               nxt_st.rdata = 32'h0;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         st_ff             <= '0;
         st_ff.state       <= CCS_ST_HOLD;
         st_ff.mcq         <= `CCS_CTRL_MCQ_RST;
         st_ff.auto_rs     <= `CCS_CTRL_AUTO_RST;
         st_ff.sel_n_seen  <= 1'b1;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign reg_rdata_out          = st_ff.rdata;
   assign codec_link_reset_n_out = st_ff.link_rst_n;
   assign audio_en_out           = st_ff.res.audio_en;
   assign modem_en_out           = st_ff.res.modem_en;

endmodule // ccs_matrix

/* tb/ccs_matrix_assertions.sv */
`timescale 1ns/100ps
`include "ccs_regs.svh"
module ccs_matrix_checker (
   input wire logic                   core_clk_in,
   input wire logic                   nrst_in,
   input wire logic                   codec_down_select_n_in,
   input wire logic [1:0]             mb_addr_in,
   input wire logic [1:0]             rs_present_in,
   input wire logic [1:0]             rs_base_addr_in,
   input wire logic [`CCS_ADDR_W-1:0] reg_addr_in,
   input wire logic                   reg_rd_in,
   input wire logic [31:0]            reg_rdata_out,
   input wire logic                   codec_link_reset_n_out,
   input wire logic [1:0]             mb_codec_reset_n_out,
   input wire logic [1:0]             mb_addr_out,
   input wire logic [1:0]             rs_addr_out,
   input wire logic [1:0]             rs_sdin_sel_out,
   input wire logic                   audio_en_out,
   input wire logic                   modem_en_out
);
   logic [1:0] up_ff;
   logic [9:0] low_cnt_ff;
   logic       fell_seen_ff;
   // Outputs lag reset release by the two-flop synchroniser
   always_ff @(posedge core_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         up_ff        <= 2'h0;
         low_cnt_ff   <= 10'h0;
         fell_seen_ff <= 1'b0;
      end else begin
         up_ff        <= (up_ff == 2'h3) ? up_ff : up_ff + 2'h1;
         low_cnt_ff   <= codec_link_reset_n_out ? 10'h0 : low_cnt_ff + 10'h1;
         fell_seen_ff <= fell_seen_ff | $fell(codec_link_reset_n_out);
      end
   end
   default clocking cb @(posedge core_clk_in);
   endclocking
   default disable iff (!nrst_in || up_ff != 2'h3);
   sequence link_up_s;
      $rose(codec_link_reset_n_out);
   endsequence
   sequence mb_live_s;
      (!codec_down_select_n_in && codec_link_reset_n_out) ##1 codec_link_reset_n_out;
   endsequence
   mb_held_a: assert property (codec_down_select_n_in |=> mb_codec_reset_n_out == 2'h0)
      else $error("motherboard codec running while select high");
   mb_run_a: assert property (mb_live_s |-> mb_codec_reset_n_out == 2'h3)
      else $error("motherboard codec held in reset while select low");
   mb_addr_a: assert property (1'b1 |=> mb_addr_out == $past(mb_addr_in))
      else $error("motherboard codec address moved");
   rs_demote_a: assert property ((!codec_down_select_n_in && rs_present_in == 2'h1) [*3]
      |-> rs_addr_out[0] && rs_sdin_sel_out[0]) else $error("lone riser codec not demoted");
   rs_keep_a: assert property ((codec_down_select_n_in && $stable(rs_base_addr_in) && $stable(rs_present_in)) [*3]
      |-> (rs_addr_out & rs_present_in) == (rs_base_addr_in & rs_present_in)) else $error("riser address moved");
   en_off_a: assert property (!codec_link_reset_n_out |-> !audio_en_out && !modem_en_out)
      else $error("function enabled during link reset");
   settle_off_a: assert property (link_up_s |-> (!audio_en_out && !modem_en_out) [*8])
      else $error("function enabled before settling");
   hold_len_a: assert property (link_up_s ##0 fell_seen_ff
      |-> low_cnt_ff inside {[`CCS_RST_HOLD_CYC - 1 : `CCS_RST_HOLD_CYC + 1]}) else $error("link reset length wrong");
   rdata_idle_a: assert property (!reg_rd_in |=> reg_rdata_out == 32'h0)
      else $error("read data outside read answer");
   sts_mirror_a: assert property (reg_rd_in && reg_addr_in == `CCS_ADDR_STATUS
      |=> reg_rdata_out[1:0] == {$past(modem_en_out), $past(audio_en_out)}) else $error("status enables differ");
endmodule // ccs_matrix_checker
bind ccs_matrix ccs_matrix_checker chk_u (.core_clk_in, .nrst_in, .codec_down_select_n_in, .mb_addr_in,
   .rs_present_in, .rs_base_addr_in, .reg_addr_in, .reg_rd_in, .reg_rdata_out, .codec_link_reset_n_out,
   .mb_codec_reset_n_out, .mb_addr_out, .rs_addr_out, .rs_sdin_sel_out, .audio_en_out, .modem_en_out);

/* tb/ccs_codec_model.sv */
`timescale 1ns/100ps
// Two codec slots per board, each {modem, audio}; zero means empty
module ccs_codec_model (
   input  wire logic       codec_down_select_n_in,
   input  wire logic [1:0] mb_codec_reset_n_in,
   input  wire logic [3:0] mb_kind_in,
   input  wire logic [3:0] rs_kind_in,
   output logic      [1:0] mb_present_out,
   output logic      [1:0] mb_audio_out,
   output logic      [1:0] mb_modem_out,
   output logic      [1:0] rs_present_out,
   output logic      [1:0] rs_audio_out,
   output logic      [1:0] rs_modem_out,
   output logic      [1:0] mb_codec_live_out
);
   logic [1:0] mb_has;
   logic [1:0] rs_has;
   assign mb_has = {|mb_kind_in[3:2], |mb_kind_in[1:0]};
   assign rs_has = {|rs_kind_in[3:2], |rs_kind_in[1:0]};
   assign mb_present_out = mb_has;
   // Two-codec motherboard pulls a lone riser codec off the link
   assign rs_present_out = (mb_has == 2'h3 && ^rs_has) ? 2'h0 : rs_has;
   assign mb_audio_out = {mb_kind_in[2], mb_kind_in[0]};
   assign mb_modem_out = {mb_kind_in[3], mb_kind_in[1]};
   assign rs_audio_out = {rs_kind_in[2], rs_kind_in[0]};
   assign rs_modem_out = {rs_kind_in[3], rs_kind_in[1]};
   // A board codec is live only while fitted, out of reset and with the select line low
   assign mb_codec_live_out = mb_has & mb_codec_reset_n_in & {2{~codec_down_select_n_in}};
endmodule // ccs_codec_model

/* tb/codec_select_function_matrix_test.sv */
`timescale 1ns/100ps
`include "ccs_regs.svh"
module codec_select_function_matrix_test;
   logic        core_clk_in, nrst_in, codec_down_select_n_in, reg_wr_in, reg_rd_in;
   logic [3:0]  mb_kind, rs_kind, reg_addr_in;
   logic [1:0]  mb_present_in, mb_audio_in, mb_modem_in, mb_addr_in;
   logic [1:0]  rs_present_in, rs_audio_in, rs_modem_in, rs_base_addr_in;
   logic [31:0] reg_wdata_in, reg_rdata_out;
   logic        codec_link_reset_n_out, audio_en_out, modem_en_out;
   logic [1:0]  mb_codec_reset_n_out, mb_addr_out, rs_addr_out, rs_sdin_sel_out, mb_live;
   int          fails, n_compared;

   ccs_matrix dut_u (.core_clk_in, .nrst_in, .codec_down_select_n_in, .mb_present_in, .mb_audio_in, .mb_modem_in,
      .mb_addr_in, .rs_present_in, .rs_audio_in, .rs_modem_in, .rs_base_addr_in, .reg_addr_in, .reg_wdata_in,
      .reg_wr_in, .reg_rd_in, .reg_rdata_out, .codec_link_reset_n_out, .mb_codec_reset_n_out, .mb_addr_out,
      .rs_addr_out, .rs_sdin_sel_out, .audio_en_out, .modem_en_out);
   ccs_codec_model model_u (.codec_down_select_n_in, .mb_codec_reset_n_in(mb_codec_reset_n_out),
      .mb_kind_in(mb_kind), .rs_kind_in(rs_kind), .mb_present_out(mb_present_in),
      .mb_audio_out(mb_audio_in), .mb_modem_out(mb_modem_in), .rs_present_out(rs_present_in),
      .rs_audio_out(rs_audio_in), .rs_modem_out(rs_modem_in), .mb_codec_live_out(mb_live));

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
      @(posedge core_clk_in);
      reg_wr_in <= 1'b1;
      reg_addr_in <= a;
      reg_wdata_in <= d;
      @(posedge core_clk_in);
      reg_wr_in <= 1'b0;
   endtask
   task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
      @(posedge core_clk_in);
      reg_rd_in <= 1'b1;
      reg_addr_in <= a;
      @(posedge core_clk_in);
      reg_rd_in <= 1'b0;
      #1 d = reg_rdata_out;
   endtask
   task automatic wait_run;
      logic [31:0] st;
      int n;
      n = 0;
      do begin
         reg_read(`CCS_ADDR_STATUS, st);
         n++;
      end while (st[`CCS_STS_STATE +: 2] !== 2'h3 && n < 1000);
      check(st[`CCS_STS_STATE +: 2], 2'h3);
   endtask
   task automatic run_eval(input logic q);
      reg_write(`CCS_ADDR_CTRL, {29'h0, 1'b1, q, 1'b1});
      repeat (4) @(posedge core_clk_in);
      check({codec_link_reset_n_out, audio_en_out, modem_en_out}, 32'h0);
      wait_run;
   endtask
   task automatic cfg(input logic s, input logic [3:0] mk, input logic [1:0] ma, input logic [3:0] rk,
                      input logic [1:0] rb, input logic q);
      @(posedge core_clk_in);
      codec_down_select_n_in <= s;
      mb_kind <= mk;
      mb_addr_in <= ma;
      rs_kind <= rk;
      rs_base_addr_in <= rb;
      run_eval(q);
   endtask
   function automatic logic [1:0] exp_en(input logic [1:0] p, input logic [1:0] s, input logic q);
      logic a;
      logic m;
      a = (p[0] | s[0]) && !(p[0] && s[0] && !q);
      m = (p[1] | s[1]) && !(p[1] && s[1]);
      if (p == 2'h0 || (p == 2'h2 && s == 2'h1)) begin
         a = 1'b0;
         m = 1'b0;
      end
      return {a, m};
   endfunction

   task automatic t_reset;
      logic [31:0] d;
      logic [31:0] e;
      check({codec_link_reset_n_out, audio_en_out, modem_en_out}, 32'h0);
      reg_read(`CCS_ADDR_CTRL, d);
      check(d, 32'h4);
      reg_read(4'h2, d);
      check(d, 32'h0);
      wait_run;
      reg_read(`CCS_ADDR_EVCNT, e);
      run_eval(1'b0);
      reg_read(`CCS_ADDR_EVCNT, d);
      check(d, e + 32'h1);
   endtask
   task automatic t_matrix;
      for (int p = 0; p < 4; p++) begin
         for (int s = 0; s < 4; s++) begin
            for (int q = 0; q < 2; q++) begin
               cfg(1'b0, {s[1:0], p[1:0]}, 2'h2, 4'h0, 2'h0, q[0]);
               check({audio_en_out, modem_en_out}, exp_en(p[1:0], s[1:0], q[0]));
               check({mb_codec_reset_n_out, mb_addr_out}, 4'he);
               check(mb_live, {|s[1:0], |p[1:0]});
            end
         end
      end
   endtask
   task automatic t_route;
      logic [31:0] d;
      cfg(1'b1, 4'h1, 2'h2, 4'h9, 2'h2, 1'b0);
      check({mb_codec_reset_n_out, mb_addr_out, rs_addr_out, audio_en_out, modem_en_out}, 8'h2b);
      check(mb_live, 2'h0);
      cfg(1'b1, 4'h1, 2'h2, 4'h9, 2'h0, 1'b0);
      check({rs_addr_out, audio_en_out, modem_en_out}, 4'h0);
      reg_read(`CCS_ADDR_STATUS, d);
      check(d[4:2], 3'h2);
      cfg(1'b0, 4'h9, 2'h0, 4'h0, 2'h0, 1'b0);
      check({audio_en_out, modem_en_out}, 2'h0);
   endtask
   task automatic t_demote;
      logic [31:0] d;
      cfg(1'b0, 4'h1, 2'h2, 4'h2, 2'h0, 1'b0);
      check({rs_addr_out, rs_sdin_sel_out, audio_en_out, modem_en_out}, 6'h17);
      reg_read(`CCS_ADDR_OCC, d);
      check(d, 32'h00110506);
      cfg(1'b1, 4'h1, 2'h2, 4'h2, 2'h0, 1'b0);
      check({rs_addr_out, rs_sdin_sel_out, audio_en_out, modem_en_out}, 6'h01);
      cfg(1'b0, 4'h9, 2'h2, 4'h1, 2'h0, 1'b0);
      check({audio_en_out, modem_en_out}, 2'h3);
   endtask
   // With auto restart off a select flip leaves the verdict standing
   task automatic t_manual;
      logic [31:0] d;
      reg_write(`CCS_ADDR_CTRL, 32'h0);
      @(posedge core_clk_in);
      codec_down_select_n_in <= 1'b1;
      repeat (4) @(posedge core_clk_in);
      reg_read(`CCS_ADDR_STATUS, d);
      check({d[9:8], d[1:0]}, 4'hf);
      @(posedge core_clk_in);
      codec_down_select_n_in <= 1'b0;
      reg_write(`CCS_ADDR_CTRL, 32'h4);
      reg_read(`CCS_ADDR_CTRL, d);
      check(d, 32'h4);
   endtask
   task automatic report_and_stop;
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   initial begin
      core_clk_in = 1'b0;
      forever #2.5 core_clk_in = ~core_clk_in;
   end
   // About 40 evaluations of roughly 620 cycles each
   initial begin
      repeat (60000) @(posedge core_clk_in);
      fails++;
      report_and_stop;
   end
   initial begin
      fails = 0;
      n_compared = 0;
      nrst_in = 1'b0;
      codec_down_select_n_in = 1'b0;
      mb_kind = 4'h0;
      rs_kind = 4'h0;
      mb_addr_in = 2'h0;
      rs_base_addr_in = 2'h0;
      reg_addr_in = 4'h0;
      reg_wdata_in = 32'h0;
      reg_wr_in = 1'b0;
      reg_rd_in = 1'b0;
      repeat (5) @(posedge core_clk_in);
      nrst_in <= 1'b1;
      repeat (3) @(posedge core_clk_in);
      t_reset;
      t_matrix;
      t_route;
      t_demote;
      t_manual;
      report_and_stop;
   end
endmodule // codec_select_function_matrix_test
